// >>> common/swrbt_pkg.sv
// package for the single-wire byte-read and triplet engine
// holds register map, field layouts, command codes and timing counts;
// assumes a 200 MHz system clock
package swrbt_pkg;

    // -----------------------------------------------------------------
    // clock and timing
    // -----------------------------------------------------------------
    localparam int CLK_PS        = 5000;                    // clock period in ps
    localparam int ACT_MAX_PS    = 262500;                  // latest line activity, ps
    localparam int ACT_MAX_CYC   = ACT_MAX_PS / CLK_PS;     // rounded down
    localparam int SLOT_STD_NS   = 70000;                   // slot_period, standard speed
    localparam int SLOT_OD_NS    = 10000;                   // slot_period, overdrive speed
    localparam int W1_STD_NS     = 6000;                    // write-one low time, standard
    localparam int W1_OD_NS      = 1000;                    // write-one low time, overdrive
    localparam int W0_STD_NS     = 60000;                   // write-zero low time, standard
    localparam int W0_OD_NS      = 8000;                    // write-zero low time, overdrive
    localparam int SMP_STD_NS    = 12000;                   // sample_point_time, standard
    localparam int SMP_OD_NS     = 1500;                    // sample_point_time, overdrive
    localparam int SLOT_STD_CYC  = (SLOT_STD_NS * 1000) / CLK_PS;
    localparam int SLOT_OD_CYC   = (SLOT_OD_NS * 1000) / CLK_PS;
    localparam int W1_STD_CYC    = (W1_STD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int W1_OD_CYC     = (W1_OD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int W0_STD_CYC    = (W0_STD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int W0_OD_CYC     = (W0_OD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int SMP_STD_CYC   = (SMP_STD_NS * 1000) / CLK_PS;
    localparam int SMP_OD_CYC    = (SMP_OD_NS * 1000) / CLK_PS;

    // -----------------------------------------------------------------
    // command codes and counts
    // -----------------------------------------------------------------
    localparam logic [7:0] CMD_READ_BYTE = 8'h96;           // eight read slots
    localparam logic [7:0] CMD_TRIPLET   = 8'h78;           // two reads, one write
    localparam logic [3:0] BYTE_LAST     = 4'h7;            // index of last byte slot
    localparam logic [3:0] TRIP_LAST     = 4'h2;            // index of last triplet slot
    localparam int         DIR_BIT       = 7;               // direction bit position

    // -----------------------------------------------------------------
    // register map (byte addresses) and reset values
    // -----------------------------------------------------------------
    localparam logic [7:0]  OFF_CMD      = 8'h00;           // command code and parameter
    localparam logic [7:0]  OFF_STATUS   = 8'h04;           // status flags
    localparam logic [7:0]  OFF_RDATA    = 8'h08;           // read data byte
    localparam logic [7:0]  OFF_CONFIG   = 8'h0C;           // speed and pullup
    localparam logic [7:0]  OFF_PTR      = 8'h10;           // read pointer select
    localparam logic [7:0]  OFF_PORT     = 8'h14;           // register under read pointer
    localparam logic [7:0]  RDATA_RST    = 8'h00;
    localparam logic        PTR_STATUS   = 1'b0;            // pointer at status
    localparam logic        PTR_RDATA    = 1'b1;            // pointer at read data

    // status register layout, bit 0 upward: busy, sbr, tsb, dir, nack
    typedef struct packed {
        logic nack;                     // last command refused
        logic dir;                      // chosen direction
        logic second_bit_result;                      // second_bit_result
        logic single_bit_result;                      // single_bit_result
        logic busy;                     // line_busy_flag
    } swrbt_status_t;

    // configuration register layout, bit 0 upward: speed, pullup
    typedef struct packed {
        logic active_pullup_enable;     // strong pullup after release
        logic overdrive_speed_select;   // overdrive slot timing
    } swrbt_config_t;

    localparam swrbt_config_t CONFIG_RST = '0;
    localparam swrbt_status_t STATUS_RST = '0;

endpackage

// >>> hw/swrbt_slot.sv
// single time-slot generator for the single-wire line
// assumes line_in is already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module swrbt_slot (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic [15:0] slot_cyc,  // slot_period in cycles, held during a slot
    input  wire logic [15:0] low1_cyc,  // write-one low time
    input  wire logic [15:0] low0_cyc,  // write-zero low time
    input  wire logic [15:0] smp_cyc,   // sample_point_time
    input  wire logic start,        // one-cycle slot request
    input  wire logic wbit,         // bit to write, 1 also reads
    input  wire logic line_in,      // synchronised line level
    output logic      line_low,     // pull the line low
    output logic      sample_stb,   // pulse at the sample point
    output logic      sample_bit,   // line level at the sample point
    output logic      slot_done     // pulse at end of slot
);
    import swrbt_pkg::*;

    logic        active;            // slot in progress
    logic        wbit_q;            // latched write bit
    logic [15:0] cnt;               // cycles into the slot
    logic [15:0] next_cnt;          // cnt plus one
    logic [15:0] low_len;           // low time for this slot

    assign next_cnt = cnt + 16'h0001;
    assign low_len  = wbit_q ? low1_cyc : low0_cyc;

    // -----------------------------------------------------------------
    // slot timing
    // -----------------------------------------------------------------
    // low phase, sample, then recovery until slot_period ends
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            active     <= 1'b0;
            wbit_q     <= 1'b1;
            cnt        <= 16'h0000;
            line_low   <= 1'b0;
            sample_stb <= 1'b0;
            sample_bit <= 1'b0;
            slot_done  <= 1'b0;
        end else if (ce) begin
            sample_stb <= 1'b0;
            slot_done  <= 1'b0;
            if (start) begin
                active   <= 1'b1;
                wbit_q   <= wbit;
                cnt      <= 16'h0000;
                line_low <= 1'b1;
            end else if (active) begin
                cnt      <= next_cnt;
                line_low <= (next_cnt < low_len);
                if (next_cnt == smp_cyc) begin
                    sample_stb <= 1'b1;
                    sample_bit <= line_in;
                end
                if (next_cnt == slot_cyc) begin
                    active    <= 1'b0;
                    line_low  <= 1'b0;
                    slot_done <= 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// >>> hw/swrbt_top.sv
// byte-read and triplet engine of a bridge's single-wire master
// assumes an APB master on clk, scl_in and line_in from outside the clock domain
//
// Operation
// - code 96h runs eight reads, stores byte
// - each byte slot is write-one, sampled
// - busy at byte-read code: refuse, no activity
// - byte read ends within eight slots
// - activity starts within 262.5ns of edge
// - busy held for the eight slots
// - accepted command points read pointer at status
// - code 78h: two reads then one write
// - both reads 0: write direction bit
// - reads 0,1: write zero
// - reads 1,0: write one
// - reads 1,1: still write one
// - busy at triplet code: refuse, ignore
// - triplet ends within three slots
// - busy for three slots, config applies
// - sbr at first sample, tsb/dir second
// - direction bit is parameter bit 7
`timescale 1ns/1ps
`default_nettype none
module swrbt_top #(
    parameter logic [15:0] SLOT_STD = 16'(swrbt_pkg::SLOT_STD_CYC),  // standard slot
    parameter logic [15:0] SLOT_OD  = 16'(swrbt_pkg::SLOT_OD_CYC),   // overdrive slot
    parameter logic [15:0] W1_STD   = 16'(swrbt_pkg::W1_STD_CYC),
    parameter logic [15:0] W1_OD    = 16'(swrbt_pkg::W1_OD_CYC),
    parameter logic [15:0] W0_STD   = 16'(swrbt_pkg::W0_STD_CYC),
    parameter logic [15:0] W0_OD    = 16'(swrbt_pkg::W0_OD_CYC),
    parameter logic [15:0] SMP_STD  = 16'(swrbt_pkg::SMP_STD_CYC),
    parameter logic [15:0] SMP_OD   = 16'(swrbt_pkg::SMP_OD_CYC)
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_in,         // serial clock from the host link
    input  wire logic        line_in,        // single-wire line level
    output logic             line_out,       // driven level, always low
    output logic             line_oe,        // high while pulling the line low
    output logic             pullup_strong   // active pullup drive
);
    import swrbt_pkg::*;

    // -----------------------------------------------------------------
    // declarations
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_SLOT} swrbt_state_t;

    swrbt_state_t  state;               // sequencer state
    swrbt_status_t status;              // status flags
    swrbt_config_t config_q;            // speed and pullup
    logic          rd_ptr;              // read pointer select
    logic [7:0]    rdata;               // read data register
    logic [7:0]    shift;               // byte being assembled
    logic          is_trip;             // running a triplet
    logic          dir_v;               // direction bit of the parameter
    logic          r0;                  // first triplet read
    logic [3:0]    idx;                 // slot index
    logic          slot_start;          // pulse to slot generator
    logic          slot_wbit;           // bit for next slot
    logic [1:0]    scl_s;               // scl synchroniser
    logic [1:0]    line_s;              // line synchroniser
    logic          scl_prev;            // delayed synchronised scl
    logic          scl_fall;            // falling scl edge
    logic          access;              // APB access cycle
    logic          wr;                  // APB write access
    logic          cmd_wr;              // write to command register
    logic          cmd_ok;              // known command code
    logic          cmd_acc;             // command accepted
    logic          mapped;              // address decodes
    logic          line_low;            // slot generator pulls low
    logic          smp_stb;             // sample point pulse
    logic          smp_bit;             // sampled level
    logic          slot_done;           // end of slot
    logic          last;                // current slot is the last
    logic          trip_dir;            // direction chosen by triplet
    logic [31:0]   next_prdata;         // read mux

    // a transfer takes effect at the edge where pready is seen high
    assign access   = psel & penable & pready;
    assign wr       = access & pwrite;
    assign cmd_wr   = wr & (paddr == OFF_CMD);
    assign cmd_ok   = (pwdata[7:0] == CMD_READ_BYTE) | (pwdata[7:0] == CMD_TRIPLET);
    assign cmd_acc  = cmd_wr & cmd_ok & ~status.busy;
    assign scl_fall = scl_prev & ~scl_s[1];
    assign last     = is_trip ? (idx == TRIP_LAST) : (idx == BYTE_LAST);
    // equal reads follow the direction bit, 1/1 forces one,
    // unequal reads follow the first read
    assign trip_dir = (r0 == smp_bit) ? (r0 | dir_v) : r0;

    // -----------------------------------------------------------------
    // input synchronisers
    // -----------------------------------------------------------------
    // two flops each; only the second stage feeds logic
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_s    <= 2'b11;
            line_s   <= 2'b11;
            scl_prev <= 1'b1;
        end else if (ce) begin
            scl_s    <= {scl_s[0], scl_in};
            line_s   <= {line_s[0], line_in};
            scl_prev <= scl_s[1];
        end
    end

    // -----------------------------------------------------------------
    // command sequencer
    // -----------------------------------------------------------------
    // accept, wait for the scl falling edge, then run the slots
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state       <= ST_IDLE;
            status.busy <= 1'b0;
            is_trip     <= 1'b0;
            dir_v       <= 1'b0;
            idx         <= 4'h0;
            slot_start  <= 1'b0;
            slot_wbit   <= 1'b1;
        end else if (ce) begin
            slot_start <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (cmd_acc) begin
                        state       <= ST_ARMED;
                        status.busy <= 1'b1;
                        is_trip     <= (pwdata[7:0] == CMD_TRIPLET);
                        dir_v       <= pwdata[8 + DIR_BIT];
                        idx         <= 4'h0;
                    end
                end
                ST_ARMED: begin
                    // reference edge: ack of code or msb of parameter
                    if (scl_fall) begin
                        state      <= ST_SLOT;
                        slot_start <= 1'b1;
                        slot_wbit  <= 1'b1;
                    end
                end
                ST_SLOT: begin
                    if (slot_done) begin
                        if (last) begin
                            state       <= ST_IDLE;
                            status.busy <= 1'b0;
                        end else begin
                            idx        <= idx + 4'h1;
                            slot_start <= 1'b1;
                            // third triplet slot writes the chosen direction
                            slot_wbit  <= (is_trip && idx == 4'h1) ? status.dir : 1'b1;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // sampled results
    // -----------------------------------------------------------------
    // byte reads shift in lsb first, triplet updates status flags
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift      <= RDATA_RST;
            rdata      <= RDATA_RST;
            r0         <= 1'b0;
            status.single_bit_result <= 1'b0;
            status.second_bit_result <= 1'b0;
            status.dir <= 1'b0;
        end else if (ce) begin
            if (smp_stb && state == ST_SLOT) begin
                if (!is_trip) begin
                    shift <= {smp_bit, shift[7:1]};
                end else if (idx == 4'h0) begin
                    r0         <= smp_bit;
                    status.single_bit_result <= smp_bit;
                end else if (idx == 4'h1) begin
                    status.second_bit_result <= smp_bit;
                    status.dir <= trip_dir;
                end
            end
            if (slot_done && state == ST_SLOT && !is_trip && last) begin
                rdata <= shift;
            end
        end
    end

    // -----------------------------------------------------------------
    // register file
    // -----------------------------------------------------------------
    // refusal flag: set on a refused command, cleared on acceptance
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status.nack <= 1'b0;
            config_q    <= CONFIG_RST;
            rd_ptr      <= PTR_STATUS;
        end else if (ce) begin
            if (cmd_wr) begin
                status.nack <= ~cmd_acc;
            end
            if (wr && paddr == OFF_CONFIG && !status.busy) begin
                config_q <= pwdata[1:0];
            end
            if (cmd_acc) begin
                rd_ptr <= PTR_STATUS;
            end else if (wr && paddr == OFF_PTR) begin
                rd_ptr <= pwdata[0];
            end
        end
    end

    // -----------------------------------------------------------------
    // APB answer
    // -----------------------------------------------------------------
    always_comb begin
        mapped      = 1'b1;
        next_prdata = 32'h0000_0000;
        case (paddr)
            OFF_CMD:    next_prdata = 32'h0000_0000;
            OFF_STATUS: next_prdata = {27'h000_0000, status};
            OFF_RDATA:  next_prdata = {24'h00_0000, rdata};
            OFF_CONFIG: next_prdata = {30'h0000_0000, config_q};
            OFF_PTR:    next_prdata = {31'h0000_0000, rd_ptr};
            OFF_PORT:   next_prdata = (rd_ptr == PTR_RDATA) ? {24'h00_0000, rdata}
                                                             : {27'h000_0000, status};
            default:    mapped      = 1'b0;
        endcase
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= mapped ? next_prdata : 32'h0000_0000;
            end
        end
    end

    // -----------------------------------------------------------------
    // line drivers
    // -----------------------------------------------------------------
    // strong pullup only while busy and the line is released
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_out      <= 1'b0;
            pullup_strong <= 1'b0;
        end else if (ce) begin
            line_out      <= 1'b0;
            pullup_strong <= config_q.active_pullup_enable & status.busy & ~line_low;
        end
    end

    assign line_oe = line_low;

    // slot timing follows the speed bit, which cannot change while busy
    swrbt_slot u_slot (
        .clk        (clk),
        .resetn     (resetn),
        .ce         (ce),
        .slot_cyc   (config_q.overdrive_speed_select ? SLOT_OD : SLOT_STD),
        .low1_cyc   (config_q.overdrive_speed_select ? W1_OD : W1_STD),
        .low0_cyc   (config_q.overdrive_speed_select ? W0_OD : W0_STD),
        .smp_cyc    (config_q.overdrive_speed_select ? SMP_OD : SMP_STD),
        .start      (slot_start),
        .wbit       (slot_wbit),
        .line_in    (line_s[1]),
        .line_low   (line_low),
        .sample_stb (smp_stb),
        .sample_bit (smp_bit),
        .slot_done  (slot_done)
    );

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    localparam int START_MAX = ACT_MAX_CYC;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn || !ce);

    sequence s_armed_edge;
        state == ST_ARMED && scl_fall;
    endsequence
    sequence s_line_low;
        line_oe;
    endsequence

    a_start_delay: assert property (s_armed_edge |-> ##[1:START_MAX] s_line_low)
        else $error("line activity late after reference edge");
    a_busy_refuse: assert property (cmd_wr && status.busy
                                    |=> status.nack && $stable(is_trip) && $stable(dir_v))
        else $error("busy command not refused");
    a_ptr_status: assert property (cmd_acc |=> rd_ptr == PTR_STATUS && state == ST_ARMED)
        else $error("read pointer not at status");
    a_busy_slots: assert property (state != ST_IDLE |-> status.busy)
        else $error("busy dropped during command");
    a_byte_store: assert property (slot_done && state == ST_SLOT && !is_trip && last
                                   |=> rdata == $past(shift) && !status.busy)
        else $error("byte not stored at end");
    a_byte_wone: assert property (slot_start && !is_trip |-> slot_wbit)
        else $error("byte read slot not write-one");
    a_trip_dir: assert property (smp_stb && state == ST_SLOT && is_trip && idx == 4'h1
        |=> status.dir == (status.single_bit_result | (~status.second_bit_result & dir_v)) && status.single_bit_result == r0)
        else $error("triplet direction wrong");
    a_trip_write: assert property (slot_start && is_trip && idx == TRIP_LAST
                                   |-> slot_wbit == status.dir)
        else $error("third slot differs from dir flag");
    a_trip_end: assert property (slot_done && state == ST_SLOT && is_trip && idx == TRIP_LAST
                                 |=> state == ST_IDLE && !status.busy)
        else $error("triplet not finished after three slots");

endmodule
`default_nettype wire

// >>> dv/swrbt_slave_model.sv
// single-wire slave stand-in: answers read slots, records slot kinds
// assumes an open-drain line with pull-up, so a released line reads high
`timescale 1ns/1ps
`default_nettype none
module swrbt_slave_model (
    input  wire logic       clk,
    input  wire logic       load,      // restart the answer pattern
    input  wire logic [7:0] rbits,     // answers, first slot in bit 0
    input  wire logic       line_oe,   // master pulls the line low
    output logic            slave_low, // slave pulls the line low
    output logic [7:0]      wr         // slot kinds seen, newest in bit 7
);
    logic [7:0] pat;   // answers still to give
    logic [7:0] low_n; // cycles since the slot began
    logic       oe_q;  // master drive one cycle ago
    // a 0 answer holds the line low past the sample point
    always_ff @(posedge clk) begin
        oe_q <= line_oe;
        low_n <= low_n + 8'h01;
        if (load) begin
            pat <= rbits;
            wr <= 8'h00;
            slave_low <= 1'b0;
        end else if (line_oe && !oe_q) begin
            slave_low <= !pat[0];
            pat <= {1'b1, pat[7:1]};
            low_n <= 8'h00;
        end else begin
            if (low_n == 8'h28) slave_low <= 1'b0;
            // a short master low is a write-one slot
            if (!line_oe && oe_q) wr <= {low_n < 8'h32, wr[7:1]};
        end
    end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the byte-read and triplet engine
// assumes short slot counts; the slave model answers the single-wire line
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import swrbt_pkg::*;
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, scl_in = 1, load = 1, lerr;
    logic [7:0] paddr = 0, rbits = 8'hFF, wr;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, line_out, line_oe, pullup_strong, slave_low;
    logic ce = 1; // clock enable, dropped once to check the freeze
    int fails = 0, samples_checked = 0;
    wire logic line_in = ~(line_oe | slave_low); // wired-low line with pull-up
    always #2.5 clk = ~clk;
    swrbt_top #(.SLOT_STD(16'd200), .W1_STD(16'd10), .W0_STD(16'd150), .SMP_STD(16'd20))
        i_swrbt_top (
        .clk(clk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scl_in(scl_in), .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
        .pullup_strong(pullup_strong));
    swrbt_slave_model i_swrbt_slave_model (.clk(clk), .load(load), .rbits(rbits),
        .line_oe(line_oe), .slave_low(slave_low), .wr(wr));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // one APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin check(0, 1); finish_test(); end
        rd = prdata;
        lerr = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clk);
    endtask
    task automatic wait_idle();
        for (int n = 0; n < 2000; n++) begin
            apb(0, OFF_STATUS, 0);
            if (rd[0] === 1'b0) return;
        end
        check(0, 1); finish_test();
    endtask
    // one link clock low phase; counts cycles until the line is pulled
    task automatic link_edge(output int c);
        scl_in <= 0;
        for (c = 0; c < 60 && line_oe !== 1'b1; c++) @(posedge clk);
        repeat (6) @(posedge clk);
        scl_in <= 1;
    endtask
    task automatic read_byte_test();
        int c;
        load <= 1; rbits <= 8'hA5; @(posedge clk); load <= 0;
        apb(1, OFF_PTR, 1);
        apb(1, OFF_CONFIG, 2);
        apb(1, OFF_CMD, {24'h0, CMD_READ_BYTE});
        link_edge(c);
        check(c <= ACT_MAX_CYC, 1);
        apb(0, OFF_PORT, 0);
        check(rd[4:0], 5'h01);
        repeat (20) @(posedge clk);
        ce <= 0;
        repeat (40) @(posedge clk);
        check(pullup_strong, 1);
        ce <= 1;
        apb(1, OFF_CMD, {16'h0, 8'h80, CMD_TRIPLET});
        apb(0, OFF_STATUS, 0);
        check(rd[4:0], 5'h11);
        wait_idle();
        check(pullup_strong, 0);
        check(line_out, 0);
        check(wr, 8'hFF);
        apb(1, OFF_PTR, 1);
        apb(0, OFF_PORT, 0);
        check(rd[7:0], 8'hA5);
    endtask
    task automatic triplet_test(input logic [2:0] k);
        int c;
        logic exp;
        exp = k[0] | (~k[1] & k[2]);
        load <= 1; rbits <= {6'h3F, k[1], k[0]}; @(posedge clk); load <= 0;
        apb(1, OFF_CMD, {16'h0, k[2], 7'h7F ^ {7{k[2]}}, CMD_TRIPLET});
        link_edge(c);
        check(c <= ACT_MAX_CYC, 1);
        if (k == 3'd0) begin
            apb(1, OFF_CMD, {24'h0, CMD_READ_BYTE});
            apb(0, OFF_STATUS, 0);
            check(rd[4:0], 5'h11);
        end
        wait_idle();
        check(rd[3:1], {exp, k[1], k[0]});
        check(wr[7:5], {exp, 2'b11});
    endtask
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1;
        @(posedge clk);
        load <= 0;
        read_byte_test();
        for (int k = 0; k < 8; k++) triplet_test(k[2:0]);
        apb(1, 8'h40, 0);
        check(lerr, 1);
        finish_test();
    end
endmodule
`default_nettype wire
